//--- hw/wan_irq_pkg.sv
/*
 constants, field layout and event carrier for the wan mac interrupt
 status block. assumes a 32-bit register port with byte addresses.
*/
// Contract
// [R1] irq only from status bits whose enable set
// [R2] reading status never alters any bit
// [R3] bits set on edge, cleared by writing one
// [R4] bit 30 sets when frame transmitted
// [R5] bit 29 sets when frame received
// [R6] bit 28 sets, transmit suspends on host-owned descriptor
// [R7] host returns ownership before transmit start command
// [R8] coincident event beats software clear
`default_nettype none

package wan_irq_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int NUM_EVENTS = 3;
    localparam logic [15:0] STATUS_ADDR = 16'he210;
    localparam logic [15:0] ENABLE_ADDR = 16'he214;
    localparam int TX_DONE_BIT = 30;
    localparam int RX_DONE_BIT = 29;
    localparam int TX_UNAVAIL_BIT = 28;
    // event vector index i sits at status bit FIELD_LSB + i
    localparam int FIELD_LSB = TX_UNAVAIL_BIT;
    localparam int TX_DONE_IDX = TX_DONE_BIT - FIELD_LSB;
    localparam int RX_DONE_IDX = RX_DONE_BIT - FIELD_LSB;
    localparam int TX_UNAVAIL_IDX = TX_UNAVAIL_BIT - FIELD_LSB;
    localparam logic [2:0] FLAG_RESET = 3'h0;
    localparam logic [2:0] ENABLE_RESET = 3'h0;
    localparam logic [31:0] READ_IDLE = 32'h0;

    // packed order matches the status bit order 30..28
    typedef struct packed {
        logic tx_done;
        logic rx_done;
        logic tx_desc_unavail;
    } wan_event_t;
endpackage

`default_nettype wire

//--- hw/sticky_edge_flag.sv
/*
 one edge-captured sticky status flag with write-one-to-clear.
 assumes the event level comes from logic on the same clock.
*/
`default_nettype none
`timescale 1ns/1ps

module sticky_edge_flag
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // event and clear
    input wire logic event_level,
    input wire logic clear_req,
    // state
    output logic rise,
    output logic flag
);
    logic prev_reg;
    logic flag_reg;

    always_ff @(posedge clk)
    begin
        if (reset)
            prev_reg <= 1'b0;
        else
            prev_reg <= event_level;
    end

    // a level held high raises the flag once only
    assign rise = event_level & ~prev_reg; // [R3]

    always_ff @(posedge clk)
    begin
        if (reset)
            flag_reg <= 1'b0;
        else if (rise)
            flag_reg <= 1'b1; // [R8]
        else if (clear_req)
            flag_reg <= 1'b0; // [R3]
    end

    assign flag = flag_reg;
endmodule // sticky_edge_flag

`default_nettype wire

//--- hw/wan_mac_interrupt_status.sv
/*
 wan mac part of the interrupt status register, its enable bits,
 the cpu interrupt line and the transmit suspend state.
 assumes mac events are levels on clk and a bus master that never
 issues read and write strobes together.
*/
`default_nettype none
`timescale 1ns/1ps

module wan_mac_interrupt_status
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire logic [wan_irq_pkg::ADDR_W-1:0] addr,
    input wire logic [wan_irq_pkg::DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [wan_irq_pkg::DATA_W-1:0] rdata,
    // mac events
    input wire wan_irq_pkg::wan_event_t mac_events,
    input wire logic tx_start_cmd,
    // outputs
    output logic irq,
    output logic tx_suspend
);
    localparam int N = wan_irq_pkg::NUM_EVENTS;
    localparam int TXD = wan_irq_pkg::TX_DONE_IDX;
    localparam int RXD = wan_irq_pkg::RX_DONE_IDX;
    localparam int TXU = wan_irq_pkg::TX_UNAVAIL_IDX;

    logic [N-1:0] event_vec;
    logic [N-1:0] rise_vec;
    logic [N-1:0] flag_vec;
    logic [N-1:0] clear_vec;
    logic [N-1:0] enable_reg;
    logic [31:0] rdata_reg;
    logic tx_suspend_reg;
    logic status_wr;
    logic enable_wr;
    logic [31:0] status_word;

    function automatic logic [N-1:0] wan_field(input logic [31:0] w);
        wan_field = w[wan_irq_pkg::FIELD_LSB +: N];
    endfunction

    function automatic logic [31:0] wan_word(input logic [N-1:0] f);
        wan_word = {{(32-N){1'b0}}, f} << wan_irq_pkg::FIELD_LSB;
    endfunction

    assign event_vec = mac_events;
    assign status_wr = wr_en && (addr == wan_irq_pkg::STATUS_ADDR);
    assign enable_wr = wr_en && (addr == wan_irq_pkg::ENABLE_ADDR);
    // only a one in the written data clears; zeros leave bits alone
    assign clear_vec = status_wr ? wan_field(wdata) : '0; // [R3]

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++)
        begin : g_flag
            sticky_edge_flag u_flag
            (
                .clk(clk),
                .reset(reset),
                .event_level(event_vec[gi]), // [R4] [R5] [R6]
                .clear_req(clear_vec[gi]),
                .rise(rise_vec[gi]),
                .flag(flag_vec[gi])
            );
        end
    endgenerate

    assign status_word = wan_word(flag_vec);

    always_ff @(posedge clk)
    begin
        if (reset)
            enable_reg <= wan_irq_pkg::ENABLE_RESET;
        else if (enable_wr)
            enable_reg <= wan_field(wdata);
    end

    // reads only sample state; no flag depends on rd_en
    always_ff @(posedge clk)
    begin
        if (reset)
            rdata_reg <= wan_irq_pkg::READ_IDLE;
        else if (rd_en && addr == wan_irq_pkg::STATUS_ADDR)
            rdata_reg <= status_word; // [R2]
        else if (rd_en && addr == wan_irq_pkg::ENABLE_ADDR)
            rdata_reg <= wan_word(enable_reg);
        else
            rdata_reg <= wan_irq_pkg::READ_IDLE;
    end

    assign rdata = rdata_reg;

    // transmit stays suspended until the host issues a start command;
    // a fresh unavailable edge in the same cycle keeps it suspended
    always_ff @(posedge clk)
    begin
        if (reset)
            tx_suspend_reg <= 1'b0;
        else if (rise_vec[TXU])
            tx_suspend_reg <= 1'b1; // [R6]
        else if (tx_start_cmd)
            tx_suspend_reg <= 1'b0; // [R6]
    end

    assign tx_suspend = tx_suspend_reg;
    // combinational so the line drops in the cycle the flag clears
    assign irq = |(flag_vec & enable_reg); // [R1]

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // a zero enable word must mask every flag at once
    property p_irq_needs_enable;
        (enable_wr && wan_field(wdata) == '0) |=> !irq;
    endproperty
    a_irq_needs_enable: assert property (p_irq_needs_enable) // [R1]
        else $error("irq high with all enables off");

    property p_irq_drops;
        (status_wr && rise_vec == '0 &&
            (wan_field(wdata) & flag_vec) == flag_vec) |=> !irq;
    endproperty
    a_irq_drops: assert property (p_irq_drops) // [R1]
        else $error("irq stayed high after all flags cleared");

    property p_rx_irq_after_edge;
        (rise_vec[RXD] && enable_reg[RXD] && !enable_wr) |=> irq;
    endproperty
    a_rx_irq_after_edge: assert property (p_rx_irq_after_edge) // [R1]
        else $error("enabled rx event did not raise irq");

    property p_read_no_clear;
        (rd_en && !wr_en) |=>
            ((flag_vec & $past(flag_vec)) == $past(flag_vec));
    endproperty
    a_read_no_clear: assert property (p_read_no_clear) // [R2]
        else $error("read access changed a status flag");

    property p_read_data;
        (rd_en && addr == wan_irq_pkg::STATUS_ADDR) |=>
            (rdata == $past(status_word));
    endproperty
    a_read_data: assert property (p_read_data) // [R2]
        else $error("status read data wrong");

    property p_enable_read;
        (rd_en && addr == wan_irq_pkg::ENABLE_ADDR) |=>
            (rdata == $past(wan_word(enable_reg)));
    endproperty
    a_enable_read: assert property (p_enable_read) // [R1]
        else $error("enable read data wrong");

    // read data stand one cycle only, so a stale word never looks fresh
    property p_rdata_idle;
        !rd_en |=> (rdata == '0);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) // [R2]
        else $error("read data not idle without a read");

    property p_zero_write_keeps;
        (status_wr && wan_field(wdata) == '0) |=>
            ((flag_vec & $past(flag_vec)) == $past(flag_vec));
    endproperty
    a_zero_write_keeps: assert property (p_zero_write_keeps) // [R3]
        else $error("writing zero cleared a flag");

    property p_one_clears;
        (status_wr && wan_field(wdata) == '1 && rise_vec == '0) |=>
            (flag_vec == '0) ##1 (flag_vec == '0 || $past(rise_vec) != '0);
    endproperty
    a_one_clears: assert property (p_one_clears) // [R3]
        else $error("writing ones did not clear flags");

    property p_tx_done_sets;
        rise_vec[TXD] |=>
            flag_vec[TXD] && status_word[wan_irq_pkg::TX_DONE_BIT];
    endproperty
    a_tx_done_sets: assert property (p_tx_done_sets) // [R4]
        else $error("tx done edge did not set bit 30");

    property p_rx_done_sets;
        rise_vec[RXD] |=> status_word[wan_irq_pkg::RX_DONE_BIT];
    endproperty
    a_rx_done_sets: assert property (p_rx_done_sets) // [R5]
        else $error("rx done edge did not set bit 29");

    property p_unavail_suspends;
        rise_vec[TXU] |=>
            status_word[wan_irq_pkg::TX_UNAVAIL_BIT] && tx_suspend;
    endproperty
    a_unavail_suspends: assert property (p_unavail_suspends) // [R6]
        else $error("unavailable edge did not suspend transmit");

    property p_suspend_holds;
        (tx_suspend && !tx_start_cmd) |=> tx_suspend;
    endproperty
    a_suspend_holds: assert property (p_suspend_holds) // [R6]
        else $error("transmit resumed without start command");

    property p_start_resumes;
        (tx_start_cmd && !rise_vec[TXU]) |=> !tx_suspend;
    endproperty
    a_start_resumes: assert property (p_start_resumes) // [R6]
        else $error("start command did not resume transmit");

    property p_set_wins;
        (rise_vec != '0 && (clear_vec & rise_vec) != '0) |=>
            ((flag_vec & $past(rise_vec)) == $past(rise_vec));
    endproperty
    a_set_wins: assert property (p_set_wins) // [R8]
        else $error("event lost to coincident clear");

    c_irq_rise: cover property ($rose(irq));
    c_set_vs_clear: cover property (rise_vec[TXD] && clear_vec[TXD]);
    c_suspend_resume: cover property (tx_suspend ##[1:20] !tx_suspend);
    c_masked_flag: cover property (flag_vec[RXD] && !enable_reg[RXD]);
    c_read_flags: cover property (rd_en && flag_vec != '0);
endmodule // wan_mac_interrupt_status

`default_nettype wire

//--- tb/wan_event_source.sv
/*
 mac event source and host resume model for the status bench.
 assumes one-cycle requests from the bench on clk.
*/
`default_nettype none
`timescale 1ns/1ps

module wan_event_source
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // requests
    input wire logic [2:0] trig,
    input wire logic resume,
    // to the block
    output var wan_irq_pkg::wan_event_t mac_events,
    output logic tx_start_cmd
);
    logic own_back_reg;

    // a one-cycle request is one event edge
    always_ff @(posedge clk)
    begin
        if (reset)
            mac_events <= 3'h0;
        else
            mac_events <= trig;
    end

    // ownership goes back a cycle before the start command
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            own_back_reg <= 1'b0;
            tx_start_cmd <= 1'b0;
        end
        else
        begin
            own_back_reg <= resume;
            tx_start_cmd <= own_back_reg;
        end
    end
endmodule // wan_event_source

`default_nettype wire

//--- tb/test_wan_mac_interrupt_status.sv
/*
 self-checking bench for the wan mac interrupt status block.
 assumes the event source model and a 100 MHz clock.
*/
`default_nettype none
`timescale 1ns/1ps

module test_wan_mac_interrupt_status;
    localparam logic [15:0] stat_a = wan_irq_pkg::STATUS_ADDR;
    localparam logic [15:0] ena_a = wan_irq_pkg::ENABLE_ADDR;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [15:0] addr = 16'h0;
    logic [31:0] wdata = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [2:0] trig = 3'h0;
    logic resume = 1'b0;
    logic [31:0] rdata;
    wan_irq_pkg::wan_event_t mac_events;
    logic tx_start_cmd;
    logic irq;
    logic tx_suspend;
    logic [2:0] st;
    logic [2:0] en;
    logic susp;
    logic [31:0] d;
    int n_fail = 0;
    int cmp_count = 0;
    int seed = 32'h7552;
    int i;

    always #5 clk = ~clk;

    wan_mac_interrupt_status uut (.clk(clk), .reset(reset), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .mac_events(mac_events), .tx_start_cmd(tx_start_cmd),
        .irq(irq), .tx_suspend(tx_suspend));
    wan_event_source far (.clk(clk), .reset(reset), .trig(trig),
        .resume(resume), .mac_events(mac_events),
        .tx_start_cmd(tx_start_cmd));

    function automatic logic [31:0] word(input logic [2:0] f);
        return {1'b0, f, 28'h0};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask

    // level returns low at once, so pulses may follow back to back
    task automatic pulse(input logic [2:0] t);
        @(posedge clk);
        trig <= t;
        @(posedge clk);
        trig <= 3'h0;
        st = st | t;
        susp = susp | t[0];
    endtask

    task automatic outs();
        rd(stat_a);
        chk("status", word(st), d);
        chk("irq", {31'h0, |(st & en)}, {31'h0, irq});
        chk("suspend", {31'h0, susp}, {31'h0, tx_suspend});
        // read data must fall back to zero one cycle after the read
        @(posedge clk);
        #1 chk("rdata idle", 32'h0, rdata);
    endtask

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        st = 3'h0;
        en = 3'h0;
        susp = 1'b0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        outs();
        rd(16'h0000);
        chk("unmapped", 32'h0, d);
        wr(ena_a, 32'hffffffff);
        rd(ena_a);
        chk("enable", 32'h70000000, d);
        wr(ena_a, 32'h0);
        $display("test reset done");
        for (i = 0; i < 3; i++)
        begin
            pulse(3'h1 << i);
            outs();
            outs();
            wr(ena_a, word(3'h1 << i));
            en = 3'h1 << i;
            outs();
            wr(stat_a, ~word(3'h1 << i));
            outs();
            wr(stat_a, word(3'h1 << i));
            st = 3'h0;
            outs();
        end
        $display("test events done");
        @(posedge clk) resume <= 1'b1;
        @(posedge clk) resume <= 1'b0;
        repeat (2) @(posedge clk);
        #1 susp = 1'b0;
        chk("resume", 32'h0, {31'h0, tx_suspend});
        $display("test resume done");
        // event edge and clear land on the same edge
        @(posedge clk) trig <= 3'h4;
        @(posedge clk) trig <= 3'h0;
        addr <= stat_a;
        wdata <= word(3'h4);
        wr_en <= 1'b1;
        @(posedge clk) wr_en <= 1'b0;
        st = 3'h4;
        outs();
        $display("test collide done");
        for (i = 0; i < 40; i++)
        begin
            d = $random(seed);
            case (d[1:0])
                2'h0: pulse(d[4:2]);
                2'h1:
                begin
                    wr(ena_a, d);
                    en = d[30:28];
                end
                2'h2:
                begin
                    wr(stat_a, d);
                    st = st & ~d[30:28];
                end
                default: rd(stat_a);
            endcase
            outs();
        end
        $display("test random done");
        // a second reset in mid-run must drop flags, enables and suspend
        @(posedge clk) reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        st = 3'h0;
        en = 3'h0;
        susp = 1'b0;
        outs();
        $display("test rereset done");
        close_out();
    end

    // whole run needs well under a thousand cycles
    initial
    begin
        repeat (3000) @(posedge clk);
        n_fail++;
        close_out();
    end
endmodule // test_wan_mac_interrupt_status

`default_nettype wire
